/* File: rtl/racc_defs.svh */
// Register map, field positions, reset values and timing constants of the address and checksum block.
`ifndef RACC_DEFS_SVH
`define RACC_DEFS_SVH
`define RACC_OFS_BASE_ADDRESS_ZERO 12'h51C
`define RACC_OFS_BASE_ADDRESS_ONE 12'h520
`define RACC_OFS_PFX_LO 12'h524
`define RACC_OFS_PFX_HI 12'h528
`define RACC_OFS_TXSEL 12'h52C
`define RACC_OFS_RXEN 12'h530
`define RACC_OFS_CHECKSUM_CONFIG 12'h534
`define RACC_OFS_POLY 12'h538
`define RACC_OFS_SEED 12'h53C
`define RACC_OFS_INTERFRAME_GAP_US 12'h544
`define RACC_OFS_STATUS 12'h5FC
`define RACC_RST_WORD 32'h00000000
`define RACC_RST_TXSEL 3'h0
`define RACC_RST_RXEN 8'h00
`define RACC_RST_LEN 2'h0
`define RACC_RST_INTERFRAME_GAP_US 10'h000
`define RACC_RST_CRC 24'h000000
`define RACC_LEN_LSB 0
`define RACC_LEN_MSB 1
`define RACC_SKIP_BIT 8
`define RACC_TXSEL_MSB 2
`define RACC_RXEN_MSB 7
`define RACC_CRC_MSB 23
`define RACC_INTERFRAME_GAP_US_MSB 9
`define RACC_ST_BUSY_BIT 0
`define RACC_ST_OK_BIT 1
`define RACC_ST_LEN_LSB 4
`define RACC_ST_LEN_MSB 5
`define RACC_CLK_MHZ 100
`define RACC_LEN_NONE 2'h0
`endif

/* File: rtl/racc_pkg.sv */
// Types shared by the address and checksum block.
package racc_pkg;
  typedef struct packed {
    logic [31:0] base_address_zero;
    logic [31:0] base_address_one;
    logic [31:0] pfx_lo;
    logic [31:0] pfx_hi;
    logic [2:0] txsel;
    logic [7:0] rxen;
    logic [1:0] crc_len;
    logic skip;
    logic [23:0] poly;
    logic [23:0] seed;
    logic [9:0] interframe_gap_us;
    logic [31:0] rdata;
    logic [39:0] tx_addr;
    logic [39:0] rx_addr;
    logic rx_accept;
    logic crc_done;
    logic crc_ok;
    logic [23:0] crc_out;
    logic [19:0] gap_cnt;
    logic gap_busy;
  } racc_state_t;

  typedef struct packed {
    logic [23:0] crc;
  } racc_crc_state_t;
endpackage

/* File: rtl/racc_crc_if.sv */
// Connection between the configuration top and the checksum engine.
`timescale 1ns/10ps
interface racc_crc_if;
  logic start;
  logic byte_valid;
  logic [7:0] data;
  logic is_addr;
  logic [1:0] len;
  logic skip;
  logic [23:0] poly;
  logic [23:0] seed;
  logic [23:0] crc;
  modport ctrl (output start, byte_valid, data, is_addr, len, skip, poly, seed, input crc);
  modport eng (input start, byte_valid, data, is_addr, len, skip, poly, seed, output crc);
endinterface

/* File: rtl/racc_crc.sv */
// Byte-wide checksum engine with programmable length, polynomial and seed.
`timescale 1ns/10ps
`include "racc_defs.svh"
module racc_crc (
  input wire logic clock,
  input wire logic rstn,
  racc_crc_if.eng bus
);
  import racc_pkg::*;

  racc_crc_state_t st;
  racc_crc_state_t next_st;

  function automatic logic [23:0] len_mask(input logic [1:0] len);
    len_mask = (24'hFFFFFF >> (5'(3 - len) * 5'h08));
  endfunction

  always_comb begin
    logic [23:0] c;
    logic [23:0] p;
    logic [4:0] top;
    logic fb;
    c = st.crc;
    p = bus.poly | 24'h000001;
    top = 5'({3'h0, bus.len} * 5'h08) - 5'h01;
    fb = 1'b0;
    next_st = st;
    if (bus.start) begin
      c = bus.seed & len_mask(bus.len);
    end
    // With a nonzero length, an address byte is dropped only when skipping and payload bytes always enter.
    if (bus.byte_valid && bus.len != `RACC_LEN_NONE && !(bus.skip && bus.is_addr)) begin
      for (int i = 7; i >= 0; i--) begin
        fb = c[top] ^ bus.data[i];
        c = c << 1;
        if (fb) begin
          c = c ^ p;
        end
      end
    end
    next_st.crc = c & len_mask(bus.len);
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      st.crc <= `RACC_RST_CRC;
    end else begin
      st <= next_st;
    end
  end

  assign bus.crc = st.crc;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  seed_load_a: assert property (bus.start && !bus.byte_valid |=> st.crc == $past(bus.seed & len_mask(bus.len)))
    else $error("Checksum not preloaded from seed.");
  skip_addr_a: assert property (!bus.start && bus.byte_valid && bus.is_addr && bus.skip |=> $stable(st.crc))
    else $error("Skipped address byte changed the checksum.");
  len_none_a: assert property (bus.len == `RACC_LEN_NONE |=> st.crc == 24'h000000)
    else $error("Checksum computed while disabled.");
  addr_fed_a: assert property (!bus.start && bus.byte_valid && bus.is_addr && !bus.skip && bus.len != 2'h0
      && bus.data != 8'h00 && st.crc == 24'h000000 |=> st.crc != 24'h000000)
    else $error("Address byte not fed into the checksum.");
  skip_cov_c: cover property (bus.byte_valid && bus.is_addr && bus.skip);
endmodule

/* File: rtl/racc_top.sv */
// Address and checksum configuration registers with packet-side address, checksum and spacing logic.
// Notes on behaviour
// - Low prefix register holds logical addresses 0-3.
// - High prefix register holds 4-7, ascending bytes.
// - Transmit address follows the selected logical address.
// - Receive accepted only on enabled logical addresses.
// - Length zero disables checksum; 1-3 bytes.
// - Skip clear: address bytes enter the checksum.
// - Skip set: checksum starts after address.
// - Polynomial bit k means term x^k.
// - Polynomial bit 0 ignored, forced one.
// - Checksum preloaded from seed each packet.
// - Gap register counts microseconds between packets.
// - Address is 2-4 base bytes plus prefix.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps
`include "racc_defs.svh"
module racc_top #(
  parameter logic [19:0] GAP_CYCLES_PER_US = 20'(`RACC_CLK_MHZ)
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [2:0] base_byte_count,
  output logic [39:0] tx_address,
  input wire logic [2:0] rx_logical,
  output logic [39:0] rx_address,
  input wire logic rx_addr_hit,
  output logic rx_accept,
  input wire logic pkt_start,
  input wire logic pkt_byte_valid,
  input wire logic [7:0] pkt_byte,
  input wire logic pkt_is_addr,
  input wire logic pkt_end,
  input wire logic pkt_is_rx,
  input wire logic [23:0] rx_crc_in,
  output logic [23:0] crc_value,
  output logic crc_done,
  output logic crc_ok,
  output logic gap_busy
);
  import racc_pkg::*;

  racc_state_t st;
  racc_state_t next_st;
  racc_crc_if crc_bus ();

  racc_crc u_crc (
    .clock(clock),
    .rstn(rstn),
    .bus(crc_bus)
  );

  assign crc_bus.start = pkt_start;
  assign crc_bus.byte_valid = pkt_byte_valid;
  assign crc_bus.data = pkt_byte;
  assign crc_bus.is_addr = pkt_is_addr;
  assign crc_bus.len = st.crc_len;
  assign crc_bus.skip = st.skip;
  assign crc_bus.poly = st.poly;
  assign crc_bus.seed = st.seed;

  // Prefix byte of a logical address; bytes sit in ascending order from bit 0.
  function automatic logic [7:0] prefix_of(input racc_state_t s, input logic [2:0] la);
    logic [63:0] all;
    all = {s.pfx_hi, s.pfx_lo};
    prefix_of = all[{la, 3'h0} +: 8];
  endfunction

  // Only the configured number of base bytes is kept; unused high bytes read as zero.
  function automatic logic [39:0] addr_of(input racc_state_t s, input logic [2:0] la, input logic [2:0] nb);
    logic [31:0] base;
    logic [31:0] keep;
    base = (la == 3'h0) ? s.base_address_zero : s.base_address_one;
    keep = 32'hFFFFFFFF >> (6'(3'h4 - nb) * 6'h08);
    addr_of = {prefix_of(s, la), base & keep};
  endfunction

  function automatic logic [23:0] crc_mask(input logic [1:0] len);
    crc_mask = 24'hFFFFFF >> (5'(3 - len) * 5'h08);
  endfunction

  always_comb begin
    logic [31:0] rd;
    rd = `RACC_RST_WORD;
    next_st = st;
    if (reg_wr) begin
      unique case (reg_addr)
        `RACC_OFS_BASE_ADDRESS_ZERO: next_st.base_address_zero = reg_wdata;
        `RACC_OFS_BASE_ADDRESS_ONE: next_st.base_address_one = reg_wdata;
        `RACC_OFS_PFX_LO: next_st.pfx_lo = reg_wdata;
        `RACC_OFS_PFX_HI: next_st.pfx_hi = reg_wdata;
        `RACC_OFS_TXSEL: next_st.txsel = reg_wdata[`RACC_TXSEL_MSB:0];
        `RACC_OFS_RXEN: next_st.rxen = reg_wdata[`RACC_RXEN_MSB:0];
        `RACC_OFS_CHECKSUM_CONFIG: begin
          next_st.crc_len = reg_wdata[`RACC_LEN_MSB:`RACC_LEN_LSB];
          next_st.skip = reg_wdata[`RACC_SKIP_BIT];
        end
        `RACC_OFS_POLY: next_st.poly = reg_wdata[`RACC_CRC_MSB:0];
        `RACC_OFS_SEED: next_st.seed = reg_wdata[`RACC_CRC_MSB:0];
        `RACC_OFS_INTERFRAME_GAP_US: next_st.interframe_gap_us = reg_wdata[`RACC_INTERFRAME_GAP_US_MSB:0];
        default: begin
        end
      endcase
    end
    unique case (reg_addr)
      `RACC_OFS_BASE_ADDRESS_ZERO: rd = st.base_address_zero;
      `RACC_OFS_BASE_ADDRESS_ONE: rd = st.base_address_one;
      `RACC_OFS_PFX_LO: rd = st.pfx_lo;
      `RACC_OFS_PFX_HI: rd = st.pfx_hi;
      `RACC_OFS_TXSEL: rd[`RACC_TXSEL_MSB:0] = st.txsel;
      `RACC_OFS_RXEN: rd[`RACC_RXEN_MSB:0] = st.rxen;
      `RACC_OFS_CHECKSUM_CONFIG: begin
        rd[`RACC_LEN_MSB:`RACC_LEN_LSB] = st.crc_len;
        rd[`RACC_SKIP_BIT] = st.skip;
      end
      `RACC_OFS_POLY: rd[`RACC_CRC_MSB:0] = st.poly;
      `RACC_OFS_SEED: rd[`RACC_CRC_MSB:0] = st.seed;
      `RACC_OFS_INTERFRAME_GAP_US: rd[`RACC_INTERFRAME_GAP_US_MSB:0] = st.interframe_gap_us;
      `RACC_OFS_STATUS: begin
        rd[`RACC_ST_BUSY_BIT] = st.gap_busy;
        rd[`RACC_ST_OK_BIT] = st.crc_ok;
        rd[`RACC_ST_LEN_MSB:`RACC_ST_LEN_LSB] = st.crc_len;
      end
      default: rd = `RACC_RST_WORD;
    endcase
    next_st.rdata = reg_rd ? rd : `RACC_RST_WORD;

    next_st.tx_addr = addr_of(st, st.txsel, base_byte_count);
    next_st.rx_addr = addr_of(st, rx_logical, base_byte_count);
    next_st.rx_accept = rx_addr_hit && st.rxen[rx_logical];

    // The engine result is read at packet end, so the last byte must come a cycle earlier.
    next_st.crc_done = pkt_end;
    if (pkt_end) begin
      next_st.crc_out = crc_bus.crc;
      if (pkt_is_rx && st.crc_len != `RACC_LEN_NONE) begin
        next_st.crc_ok = (crc_bus.crc == (rx_crc_in & crc_mask(st.crc_len)));
      end else begin
        next_st.crc_ok = 1'b1;
      end
    end

    // A new packet end restarts the gap even if the previous one is still running.
    if (pkt_end) begin
      next_st.gap_cnt = 20'(st.interframe_gap_us * GAP_CYCLES_PER_US);
      next_st.gap_busy = (st.interframe_gap_us != `RACC_RST_INTERFRAME_GAP_US);
    end else if (st.gap_cnt != 20'h00000) begin
      next_st.gap_cnt = st.gap_cnt - 20'h00001;
      next_st.gap_busy = (st.gap_cnt != 20'h00001);
    end else begin
      next_st.gap_busy = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      st.base_address_zero <= `RACC_RST_WORD;
      st.base_address_one <= `RACC_RST_WORD;
      st.pfx_lo <= `RACC_RST_WORD;
      st.pfx_hi <= `RACC_RST_WORD;
      st.txsel <= `RACC_RST_TXSEL;
      st.rxen <= `RACC_RST_RXEN;
      st.crc_len <= `RACC_RST_LEN;
      st.skip <= 1'b0;
      st.poly <= `RACC_RST_CRC;
      st.seed <= `RACC_RST_CRC;
      st.interframe_gap_us <= `RACC_RST_INTERFRAME_GAP_US;
      st.rdata <= `RACC_RST_WORD;
      st.tx_addr <= 40'h0000000000;
      st.rx_addr <= 40'h0000000000;
      st.rx_accept <= 1'b0;
      st.crc_done <= 1'b0;
      st.crc_ok <= 1'b0;
      st.crc_out <= `RACC_RST_CRC;
      st.gap_cnt <= 20'h00000;
      st.gap_busy <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign tx_address = st.tx_addr;
  assign rx_address = st.rx_addr;
  assign rx_accept = st.rx_accept;
  assign crc_value = st.crc_out;
  assign crc_done = st.crc_done;
  assign crc_ok = st.crc_ok;
  assign gap_busy = st.gap_busy;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  rx_disabled_a: assert property (rx_addr_hit && !st.rxen[rx_logical] |=> !rx_accept)
    else $error("Packet accepted on a disabled logical address.");
  rx_enabled_a: assert property (rx_addr_hit && st.rxen[rx_logical] |=> rx_accept)
    else $error("Packet refused on an enabled logical address.");
  tx_prefix_a: assert property (##1 tx_address[39:32] == $past(prefix_of(st, st.txsel)))
    else $error("Transmit prefix does not follow the selector.");
  rx_base_a: assert property (rx_logical != 3'h0 && base_byte_count == 3'h4
      |=> rx_address[31:0] == $past(st.base_address_one))
    else $error("Wrong base for nonzero logical address.");
  short_base_a: assert property (base_byte_count == 3'h2 |=> tx_address[31:16] == 16'h0000)
    else $error("Base bytes beyond configured length leaked.");
  crc_none_a: assert property (pkt_end && st.crc_len == `RACC_LEN_NONE |=> crc_ok && crc_done)
    else $error("Disabled checksum reported a mismatch.");
  crc_cmp_a: assert property (pkt_end && pkt_is_rx && st.crc_len != 2'h0
      |=> crc_ok == ($past(crc_bus.crc) == ($past(rx_crc_in) & crc_mask($past(st.crc_len)))))
    else $error("Receive checksum comparison wrong.");
  gap_start_a: assert property (pkt_end && st.interframe_gap_us != 10'h000 |=> gap_busy ##0 st.gap_cnt != 20'h00000)
    else $error("Gap did not start after packet end.");
  gap_end_a: assert property (!pkt_end && st.gap_cnt == 20'h00001 |=> !gap_busy)
    else $error("Gap outlasted its count.");
  txsel_rd_a: assert property (reg_rd && reg_addr == `RACC_OFS_TXSEL && !$past(reg_wr)
      |=> reg_rdata == {29'h00000000, $past(st.txsel)})
    else $error("Selector read back wrong.");

  // Decode guards: a write must land in exactly the field that the offset names.
  txsel_wr_a: assert property (reg_wr && reg_addr == `RACC_OFS_TXSEL
      |=> st.txsel == $past(reg_wdata[`RACC_TXSEL_MSB:0]))
    else $error("Selector write lost.");
  rxen_wr_a: assert property (reg_wr && reg_addr == `RACC_OFS_RXEN
      |=> st.rxen == $past(reg_wdata[`RACC_RXEN_MSB:0]))
    else $error("Receive enable write lost.");
  cnf_wr_a: assert property (reg_wr && reg_addr == `RACC_OFS_CHECKSUM_CONFIG
      |=> st.crc_len == $past(reg_wdata[`RACC_LEN_MSB:`RACC_LEN_LSB]) && st.skip == $past(reg_wdata[`RACC_SKIP_BIT]))
    else $error("Checksum configuration write lost.");
  poly_wr_a: assert property (reg_wr && reg_addr == `RACC_OFS_POLY
      |=> st.poly == $past(reg_wdata[`RACC_CRC_MSB:0]))
    else $error("Polynomial write lost.");
  seed_wr_a: assert property (reg_wr && reg_addr == `RACC_OFS_SEED
      |=> st.seed == $past(reg_wdata[`RACC_CRC_MSB:0]))
    else $error("Seed write lost.");
  pfx_wr_a: assert property (reg_wr && reg_addr == `RACC_OFS_PFX_HI
      |=> st.pfx_hi == $past(reg_wdata))
    else $error("High prefix write lost.");

  // Read side: data only in the cycle after the strobe, reserved bits zero.
  rd_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h00000000)
    else $error("Read data present without a read strobe.");
  interframe_gap_us_rd_a: assert property (reg_rd && reg_addr == `RACC_OFS_INTERFRAME_GAP_US
      |=> reg_rdata == {22'h0, $past(st.interframe_gap_us)})
    else $error("Gap register read back wrong.");
  status_rd_a: assert property (reg_rd && reg_addr == `RACC_OFS_STATUS
      |=> reg_rdata[`RACC_ST_BUSY_BIT] == $past(gap_busy))
    else $error("Status busy bit wrong.");

  // Address build: prefix byte and base bytes for every logical address.
  pfx_low_a: assert property (rx_logical < 3'h4
      |=> rx_address[39:32] == $past(st.pfx_lo[{rx_logical[1:0], 3'h0} +: 8]))
    else $error("Low prefix byte misplaced.");
  pfx_high_a: assert property (rx_logical >= 3'h4
      |=> rx_address[39:32] == $past(st.pfx_hi[{rx_logical[1:0], 3'h0} +: 8]))
    else $error("High prefix byte misplaced.");
  rx_base_address_zero_a: assert property (rx_logical == 3'h0 && base_byte_count == 3'h4
      |=> rx_address[31:0] == $past(st.base_address_zero))
    else $error("Wrong base for logical address zero.");
  mid_base_a: assert property (base_byte_count == 3'h3 |=> rx_address[31:24] == 8'h00)
    else $error("Fourth base byte leaked.");
  tx_base_a: assert property (base_byte_count == 3'h4
      |=> tx_address[31:0] == $past(st.txsel == 3'h0 ? st.base_address_zero : st.base_address_one))
    else $error("Transmit base does not follow the selector.");

  // Results: one-cycle done pulse, values held until the next packet end.
  accept_idle_a: assert property (!rx_addr_hit |=> !rx_accept)
    else $error("Accept without an address hit.");
  done_pulse_a: assert property (!pkt_end |=> !crc_done)
    else $error("Done without a packet end.");
  result_hold_a: assert property (!pkt_end |=> $stable(crc_ok) && $stable(crc_value))
    else $error("Checksum result changed between packets.");
  crc_val_a: assert property (pkt_end |=> crc_value == $past(crc_bus.crc))
    else $error("Captured checksum differs from engine.");
  tx_ok_a: assert property (pkt_end && !pkt_is_rx |=> crc_ok)
    else $error("Transmit packet reported a mismatch.");
  gap_count_a: assert property (gap_busy |-> st.gap_cnt != 20'h00000)
    else $error("Gap busy with an empty counter.");

  rx_cov_c: cover property (rx_addr_hit ##1 rx_accept);
  crc_good_c: cover property (pkt_end && pkt_is_rx && st.crc_len == 2'h3 ##1 crc_ok);
  gap_done_c: cover property (gap_busy ##1 !gap_busy);
  crc_bad_c: cover property (crc_done && !crc_ok);
endmodule

/* File: sim/racc_peer.sv */
// Behavioural remote transceiver that feeds one packet into the block on request.
`timescale 1ns/10ps
module racc_peer (
  input wire logic clock,
  input wire logic go,
  input wire logic slow,
  input wire logic is_rx,
  input wire logic [55:0] pkt,
  input wire logic [23:0] crc_rx,
  output logic pkt_start,
  output logic pkt_byte_valid,
  output logic [7:0] pkt_byte,
  output logic pkt_is_addr,
  output logic pkt_end,
  output logic pkt_is_rx,
  output logic [23:0] rx_crc_in
);
  initial begin
    pkt_start = 1'b0;
    pkt_byte_valid = 1'b0;
    pkt_byte = 8'h00;
    pkt_is_addr = 1'b0;
    pkt_end = 1'b0;
    pkt_is_rx = 1'b0;
    rx_crc_in = 24'h000000;
  end
  // Three address bytes then four payload bytes, back to back.
  always begin
    @(posedge clock);
    if (go) begin
      // In slow mode the preload comes alone, a cycle ahead of the first byte.
      if (slow) begin
        pkt_start <= 1'b1;
        @(posedge clock);
      end
      for (int i = 0; i < 7; i++) begin
        pkt_start <= (i == 0) && !slow;
        pkt_byte_valid <= 1'b1;
        pkt_byte <= pkt[55-8*i -: 8];
        pkt_is_addr <= (i < 3);
        @(posedge clock);
      end
      // Start and byte strobes drop to zero; the other released lines carry the inverse of their last value so stale data cannot pass by chance.
      pkt_start <= 1'b0;
      pkt_byte_valid <= 1'b0;
      pkt_byte <= ~pkt[7:0];
      pkt_is_addr <= 1'b1;
      repeat (slow ? 4 : 0) @(posedge clock);
      pkt_end <= 1'b1;
      pkt_is_rx <= is_rx;
      rx_crc_in <= crc_rx;
      @(posedge clock);
      pkt_end <= 1'b0;
      pkt_is_rx <= ~is_rx;
      rx_crc_in <= ~crc_rx;
    end
  end
endmodule

/* File: sim/tb.sv */
// Self-checking bench for the address and checksum block.
`timescale 1ns/10ps
module tb;
  logic clock, rstn, reg_wr, reg_rd, rx_addr_hit, go, slow, is_rx, rd_d;
  logic rx_accept, pkt_start, pkt_byte_valid, pkt_is_addr, pkt_end, pkt_is_rx, crc_done, crc_ok, gap_busy;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rng, r, v;
  logic [2:0] base_byte_count, rx_logical;
  logic [39:0] tx_address, rx_address, ea;
  logic [7:0] pkt_byte;
  logic [23:0] rx_crc_in, crc_value, crc_rx, c;
  logic [55:0] pkt, p;
  logic [63:0] pf;
  logic [31:0] b0, b1;
  logic [25:0] me;
  logic [31:0] q_rd[$];
  logic [25:0] q_crc[$];
  logic [11:0] ofs[11] = '{12'h51C, 12'h520, 12'h524, 12'h528, 12'h52C, 12'h530, 12'h534, 12'h538, 12'h53C,
    12'h544, 12'h540};
  logic [31:0] msk[11] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h7, 32'hFF, 32'h103,
    32'hFFFFFF, 32'hFFFFFF, 32'h3FF, 32'h0};
  int err_count, n_tests, cyc;
  logic [1:0] len;
  logic ok, sk;

  racc_top #(.GAP_CYCLES_PER_US(20'h1)) i_dut (.clock, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .base_byte_count, .tx_address, .rx_logical, .rx_address, .rx_addr_hit, .rx_accept, .pkt_start,
    .pkt_byte_valid, .pkt_byte, .pkt_is_addr, .pkt_end, .pkt_is_rx, .rx_crc_in, .crc_value, .crc_done, .crc_ok,
    .gap_busy);
  racc_peer i_peer (.clock, .go, .slow, .is_rx, .pkt, .crc_rx, .pkt_start, .pkt_byte_valid, .pkt_byte,
    .pkt_is_addr, .pkt_end, .pkt_is_rx, .rx_crc_in);

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  // Reference checksum: MSB first, width of len bytes, constant term always present.
  function automatic logic [23:0] crc_ref(logic [1:0] l, logic sk, logic [23:0] po, logic [23:0] sd,
    logic [55:0] d);
    logic [23:0] m, x;
    logic fb;
    if (l == 2'h0) return 24'h0;
    m = 24'hFFFFFF >> (8 * (3 - l));
    x = sd & m;
    for (int i = (sk ? 3 : 0); i < 7; i++) begin
      for (int b = 7; b >= 0; b--) begin
        fb = x[8*l-1] ^ d[48-8*i+b];
        x = (x << 1) & m;
        if (fb) x ^= (po | 24'h1) & m;
      end
    end
    return x;
  endfunction

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    // Notes never matched by a result count as mismatches, so a hang cannot pass.
    err_count += q_rd.size() + q_crc.size();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    q_rd.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask

  task automatic idle();
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge clock);
  endtask

  task automatic send(input logic [55:0] d, input logic [23:0] cr, input logic [25:0] e);
    q_crc.push_back(e);
    pkt <= d;
    crc_rx <= cr;
    go <= 1'b1;
    reg_wr <= 1'b0;
    @(posedge clock);
    go <= 1'b0;
    for (int n = 0; n < 40 && crc_done !== 1'b1; n++) @(posedge clock);
  endtask

  // Results are compared as they appear, against notes left by the driver.
  always @(posedge clock) begin
    if (rd_d && q_rd.size() > 0) chk(40'(reg_rdata), 40'(q_rd.pop_front()));
    if (crc_done === 1'b1 && q_crc.size() > 0) begin
      me = q_crc.pop_front();
      chk(40'(crc_value), 40'(me[25:2]));
      chk(40'(crc_ok), 40'(me[1]));
      chk(40'(gap_busy), 40'(me[0]));
    end
    rd_d <= reg_rd;
    cyc++;
    if (cyc > 20000) begin
      err_count++;
      wrap_up();
    end
  end

  initial begin
    {reg_wr, reg_rd, rx_addr_hit, go, slow, is_rx, rstn} = 7'h00;
    reg_addr = 12'h000;
    reg_wdata = 32'h0;
    base_byte_count = 3'h4;
    rx_logical = 3'h0;
    pkt = 56'h0;
    crc_rx = 24'h0;
    rng = 32'h9012;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    for (int i = 0; i < 11; i++) rd(ofs[i], 32'h0);
    $display("reset values done");
    for (int i = 0; i < 11; i++) begin
      v = rnd();
      wr(ofs[i], v);
      rd(ofs[i], v & msk[i]);
    end
    $display("register access done");
    b0 = rnd();
    b1 = rnd();
    pf = {rnd(), rnd()};
    wr(12'h51C, b0);
    wr(12'h520, b1);
    wr(12'h524, pf[31:0]);
    wr(12'h528, pf[63:32]);
    for (int la = 0; la < 8; la++) begin
      for (int n = 2; n < 5; n++) begin
        wr(12'h52C, 32'(la));
        rx_logical <= 3'(la);
        base_byte_count <= 3'(n);
        idle();
        idle();
        ea = {pf[8*la +: 8], (la == 0 ? b0 : b1) & (32'hFFFFFFFF >> (8 * (4 - n)))};
        chk(tx_address, ea);
        chk(rx_address, ea);
      end
    end
    $display("address build done");
    r = rnd();
    wr(12'h530, r);
    idle();
    for (int la = 0; la < 8; la++) begin
      rx_logical <= 3'(la);
      rx_addr_hit <= 1'b1;
      @(posedge clock);
      rx_addr_hit <= 1'b0;
      #1 chk(40'(rx_accept), 40'(r[la]));
      @(posedge clock);
    end
    $display("receive gate done");
    wr(12'h544, 32'h0);
    for (int k = 0; k < 16; k++) begin
      len = 2'(k);
      slow <= k[2];
      is_rx <= k[3];
      sk = k[2] ^ k[1];
      p = {rnd(), rnd()};
      v = rnd();
      // Zero seeds in the first half let an address byte meet an empty checksum.
      r = rnd() & {32{k[3]}};
      wr(12'h534, {23'h0, sk, 6'h0, len});
      wr(12'h538, v);
      wr(12'h53C, r);
      c = crc_ref(len, sk, v[23:0], r[23:0], p);
      ok = !(k[3] && k[0]);
      send(p, ok ? c : c ^ 24'h1, {c, ok, 1'b0});
    end
    $display("checksum done");
    wr(12'h544, 32'h5);
    is_rx <= 1'b0;
    send(p, 24'h0, {c, 1'b1, 1'b1});
    rd(12'h5FC, 32'h33);
    idle();
    chk(40'(gap_busy), 40'h1);
    repeat (8) @(posedge clock);
    chk(40'(gap_busy), 40'h0);
    $display("gap done");
    wrap_up();
  end
endmodule
